// File: hdl/pcd_decoder.sv
// clock mode strap decoder with ahb-lite register access
`timescale 1ns/1ps
// Functional notes
// [RULE1] join high and low fields, range select picks table
// [RULE2] select0 0111: reserved 000, core 3..4.5
// [RULE3] select0 1000: core 3..6.5, division 4
// [RULE4] select0 1001_010..100: factor 3.5, division 4
// [RULE5] select0 1001_101..111: core 5..6, division 6
// [RULE6] select0 1010_000..010: factor 2, division 3
// [RULE7] select0 0110_011..110: factor 2.5, division 3; the code also decodes 0110_111 as valid
// [RULE8] select1 0010_110: factors 4, 6, division 6
// [RULE9] select1 0011: factor 5, core 5..8
// [RULE10] select1 0100: reserved 000, factor 6
// [RULE11] select1 0101: factor 2, division 4
// [RULE12] select1 0110: factor 2.5, division 6
// [RULE13] select1 0111: factor 3, division 6
// [RULE14] select1 1000: factor 3, division 8
// [RULE15] select1 1001: division 8 then 6
// [RULE16] select1 1010: factor 2, division 6
// [RULE17] select1 1011: factor 2.5, division 8
// [RULE18] select1 1101_000: factors 2.5, 3, division 5
// [RULE19] 133 MHz bus needs board-level configuration
// [RULE20] impedance chosen by config bits 20, 21
// [RULE21] heavy loads: software sets both low-impedance bits
// [RULE22] reserved or uncovered code flags invalid
module pcd_decoder
   import pcd_pkg::*;
#(
   // silicon revision code; PCD_REV_FIXED_IMP disables the impedance select bits
   parameter logic [3:0] SILICON_REV = 4'h1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [3:0] clock_mode_high_field,
   input wire logic [2:0] clock_mode_low_field,
   input wire logic pci_clock_range_select,
   output logic decode_valid,
   output logic config_invalid,
   output logic [4:0] comm_factor_x2,
   output logic [4:0] core_factor_x2,
   output logic [3:0] pci_division,
   output logic bus_low_impedance_sel_0,
   output logic bus_low_impedance_sel_1
);

   // ==========================================================
   // decode table
   function automatic pcd_decode_t pcd_lookup(input pcd_strap_t s);
      pcd_decode_t d;
      logic [4:0] lo;
      d = '{invalid: 1'b0, comm_x2: 5'h00, core_x2: 5'h00, pci_div: 4'h0};
      lo = {2'b00, s.low};
      case ({s.sel, s.high}) // see [RULE1]
         5'h06: begin
            if (s.low >= 3'h3) begin // see [RULE7]
               d.comm_x2 = 5'h05;
               d.core_x2 = (s.low == 3'h6) ? 5'h0c : lo + 5'h05;
               d.pci_div = 4'h3;
            end else
               d.invalid = 1'b1;
         end
         5'h07, 5'h17: begin
            if (s.low != 3'h0 && s.low <= 3'h4) begin // see [RULE2] see [RULE13]
               d.comm_x2 = 5'h06;
               d.core_x2 = lo + 5'h05;
               d.pci_div = s.sel ? 4'h6 : 4'h3;
            end else
               d.invalid = 1'b1;
         end
         5'h08, 5'h18: begin
            if (s.low != 3'h0 && s.low <= 3'h6) begin // see [RULE3] see [RULE14]
               d.comm_x2 = 5'h06;
               d.core_x2 = (s.low <= 3'h4) ? lo + 5'h05 : lo + 5'h07;
               d.pci_div = s.sel ? 4'h8 : 4'h4;
            end else
               d.invalid = 1'b1;
         end
         5'h09, 5'h19: begin
            d.comm_x2 = 5'h07;
            if (s.low <= 3'h1)
               d.invalid = 1'b1; // see [RULE4] see [RULE15]
            else if (s.low <= 3'h4) begin
               d.core_x2 = lo + 5'h05; // see [RULE4]
               d.pci_div = s.sel ? 4'h8 : 4'h4; // see [RULE15]
            end else begin
               d.core_x2 = lo + 5'h05; // see [RULE5]
               d.pci_div = 4'h6;
            end
         end
         5'h0a: begin
            if (s.low <= 3'h2) begin // see [RULE6]
               d.comm_x2 = 5'h04;
               d.core_x2 = lo + 5'h04;
               d.pci_div = 4'h3;
            end else
               d.invalid = 1'b1;
         end
         5'h12: begin
            if (s.low == 3'h6) begin // see [RULE8]
               d.comm_x2 = 5'h08;
               d.core_x2 = 5'h0c;
               d.pci_div = 4'h6;
            end else
               d.invalid = 1'b1;
         end
         5'h13: begin
            if (s.low <= 3'h3) begin // see [RULE9]
               d.comm_x2 = 5'h0a;
               d.core_x2 = 5'h0a + {lo[3:0], 1'b0};
               d.pci_div = 4'h5;
            end else
               d.invalid = 1'b1;
         end
         5'h14: begin
            if (s.low != 3'h0 && s.low <= 3'h3) begin // see [RULE10]
               d.comm_x2 = 5'h0c;
               d.core_x2 = 5'h0a + {lo[3:0], 1'b0};
               d.pci_div = 4'h6;
            end else
               d.invalid = 1'b1;
         end
         5'h15: begin
            if (s.low <= 3'h4) begin // see [RULE11]
               d.comm_x2 = 5'h04;
               d.core_x2 = lo + 5'h05;
               d.pci_div = 4'h4;
            end else
               d.invalid = 1'b1;
         end
         5'h16: begin
            if (s.low <= 3'h6) begin // see [RULE12]
               d.comm_x2 = 5'h05;
               d.core_x2 = (s.low == 3'h6) ? 5'h0c : lo + 5'h05;
               d.pci_div = 4'h6;
            end else
               d.invalid = 1'b1;
         end
         5'h1a: begin
            if (s.low <= 3'h4) begin // see [RULE16]
               d.comm_x2 = 5'h04;
               d.core_x2 = lo + 5'h04;
               d.pci_div = 4'h6;
            end else
               d.invalid = 1'b1;
         end
         5'h1b: begin
            if (s.low != 3'h0 && s.low <= 3'h5) begin // see [RULE17]
               d.comm_x2 = 5'h05;
               d.core_x2 = lo + 5'h04;
               d.pci_div = 4'h8;
            end else
               d.invalid = 1'b1;
         end
         5'h1d: begin
            if (s.low == 3'h0) begin // see [RULE18]
               d.comm_x2 = 5'h05;
               d.core_x2 = 5'h06;
               d.pci_div = 4'h5;
            end else
               d.invalid = 1'b1;
         end
         default: d.invalid = 1'b1;
      endcase
      if (d.invalid) begin // see [RULE22]
         d.comm_x2 = PCD_FACTOR_RST;
         d.core_x2 = PCD_FACTOR_RST;
         d.pci_div = PCD_DIV_RST;
      end
      return d;
   endfunction

   // ==========================================================
   // strap capture after reset release or on software request
   logic capture_pending_r;
   logic resample_req;
   pcd_strap_t strap_r;
   pcd_decode_t dec_r;
   logic decode_valid_r;
   logic imp0_r;
   logic imp1_r;
   logic imp_selectable;

   assign imp_selectable = (SILICON_REV != PCD_REV_FIXED_IMP);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         capture_pending_r <= 1'b1;
      else if (resample_req)
         capture_pending_r <= 1'b1;
      else
         capture_pending_r <= 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         strap_r <= '0;
      else if (capture_pending_r)
         strap_r <= '{sel: pci_clock_range_select, high: clock_mode_high_field,
                      low: clock_mode_low_field}; // see [RULE1]
   end

   // decode lags the capture by one cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dec_r <= '{invalid: 1'b0, comm_x2: PCD_FACTOR_RST, core_x2: PCD_FACTOR_RST, pci_div: PCD_DIV_RST};
         decode_valid_r <= 1'b0;
      end else if (capture_pending_r) begin
         decode_valid_r <= 1'b0;
      end else begin
         dec_r <= pcd_lookup(strap_r);
         decode_valid_r <= 1'b1;
      end
   end

   // ==========================================================
   // ahb-lite slave, zero wait states, always okay
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic addr_phase;
   logic [31:0] rd_mux;

   assign addr_phase = hsel && htrans[1] && hready;
   assign resample_req = wr_pend_r && (wr_addr_r == PCD_CTRL_OFS) && hwdata[PCD_CTRL_RESAMPLE_BIT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= addr_phase && hwrite;
         wr_addr_r <= haddr[7:0];
      end
   end

   // low-impedance bits are writable only on revisions that have them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         imp0_r <= 1'b0;
         imp1_r <= 1'b0;
      end else if (wr_pend_r && wr_addr_r == PCD_SYSCFG_OFS && imp_selectable) begin
         imp0_r <= hwdata[PCD_SYSCFG_IMP0_BIT]; // see [RULE20]
         imp1_r <= hwdata[PCD_SYSCFG_IMP1_BIT]; // see [RULE20]
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (haddr[7:0])
         PCD_CTRL_OFS: rd_mux[PCD_CTRL_RESAMPLE_BIT] = capture_pending_r;
         PCD_STRAP_OFS: begin
            rd_mux[6:0] = {strap_r.high, strap_r.low};
            rd_mux[PCD_STRAP_SEL_BIT] = strap_r.sel;
         end
         PCD_DECODE_OFS: begin
            rd_mux[4:0] = dec_r.comm_x2;
            rd_mux[PCD_DEC_CORE_LSB +: 5] = dec_r.core_x2;
            rd_mux[PCD_DEC_DIV_LSB +: 4] = dec_r.pci_div;
            rd_mux[PCD_DEC_INVALID_BIT] = dec_r.invalid;
         end
         PCD_SYSCFG_OFS: begin
            rd_mux[PCD_SYSCFG_IMP0_BIT] = imp0_r;
            rd_mux[PCD_SYSCFG_IMP1_BIT] = imp1_r;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= PCD_HRDATA_RST;
      else if (addr_phase && !hwrite)
         hrdata <= rd_mux;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ==========================================================
   // registered outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         decode_valid <= 1'b0;
         config_invalid <= 1'b0;
         comm_factor_x2 <= PCD_FACTOR_RST;
         core_factor_x2 <= PCD_FACTOR_RST;
         pci_division <= PCD_DIV_RST;
         bus_low_impedance_sel_0 <= 1'b0;
         bus_low_impedance_sel_1 <= 1'b0;
      end else begin
         decode_valid <= decode_valid_r;
         config_invalid <= decode_valid_r && dec_r.invalid; // see [RULE22]
         comm_factor_x2 <= dec_r.comm_x2;
         core_factor_x2 <= dec_r.core_x2;
         pci_division <= dec_r.pci_div;
         bus_low_impedance_sel_0 <= imp0_r;
         bus_low_impedance_sel_1 <= imp1_r;
      end
   end

endmodule // pcd_decoder

// File: hdl/pcd_pkg.sv
// shared constants and types for the pci host clock mode decoder
package pcd_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] PCD_CTRL_OFS = 8'h00;
   localparam logic [7:0] PCD_STRAP_OFS = 8'h04;
   localparam logic [7:0] PCD_DECODE_OFS = 8'h08;
   localparam logic [7:0] PCD_SYSCFG_OFS = 8'h0c;
   // ==========================================================
   // field positions
   localparam int PCD_CTRL_RESAMPLE_BIT = 0;
   localparam int PCD_STRAP_SEL_BIT = 8;
   localparam int PCD_DEC_CORE_LSB = 8;
   localparam int PCD_DEC_DIV_LSB = 16;
   localparam int PCD_DEC_INVALID_BIT = 31;
   localparam int PCD_SYSCFG_IMP0_BIT = 20;
   localparam int PCD_SYSCFG_IMP1_BIT = 21;
   // ==========================================================
   // reset values
   localparam logic [31:0] PCD_HRDATA_RST = 32'h0000_0000;
   localparam logic [4:0] PCD_FACTOR_RST = 5'h00;
   localparam logic [3:0] PCD_DIV_RST = 4'h0;
   // silicon revision without the impedance choice
   localparam logic [3:0] PCD_REV_FIXED_IMP = 4'h0;
   // ==========================================================
   // decode result; factors are held doubled so half steps stay integral
   typedef struct packed {
      logic invalid;
      logic [4:0] comm_x2;
      logic [4:0] core_x2;
      logic [3:0] pci_div;
   } pcd_decode_t;
   typedef struct packed {
      logic sel;
      logic [3:0] high;
      logic [2:0] low;
   } pcd_strap_t;
endpackage

// File: verification/pcd_strap_board.sv
// board strapping model driving the clock mode straps
`timescale 1ns/1ps
module pcd_strap_board
   import pcd_pkg::*;
(
   input wire logic hclk,
   output logic [3:0] clock_mode_high_field,
   output logic [2:0] clock_mode_low_field,
   output logic pci_clock_range_select
);
   // ==========================================================
   // strap levels
   // straps power up on a covered code and change only after a rising edge
   initial begin
      {pci_clock_range_select, clock_mode_high_field, clock_mode_low_field} = 8'he8;
   end
   task automatic drive(input pcd_strap_t s);
      @(posedge hclk);
      pci_clock_range_select <= s.sel;
      clock_mode_high_field <= s.high;
      clock_mode_low_field <= s.low;
   endtask
endmodule // pcd_strap_board

// File: verification/pcd_decoder_asserts.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module pcd_decoder_asserts
   import pcd_pkg::*;
#(
   parameter logic [3:0] SILICON_REV = 4'h1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic decode_valid,
   input wire logic config_invalid,
   input wire logic [4:0] comm_factor_x2,
   input wire logic [4:0] core_factor_x2,
   input wire logic [3:0] pci_division,
   input wire logic bus_low_impedance_sel_0,
   input wire logic bus_low_impedance_sel_1
);
   // ==========================================================
   // decode and impedance checks
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic good;
   assign good = decode_valid && !config_invalid;
   sequence s_req(logic [31:0] a);
      hsel && htrans[1] && hready && hwrite && haddr == a ##1 1'b1;
   endsequence
   sequence s_held;
      decode_valid ##1 decode_valid;
   endsequence
   a_invalid_zero: assert property (config_invalid |-> {comm_factor_x2, core_factor_x2, pci_division} == 14'h0)
      else $error("factors shown on an invalid code");
   a_invalid_in_valid: assert property (config_invalid |-> decode_valid)
      else $error("invalid flag without a decode");
   a_factors_set: assert property (good |-> comm_factor_x2 != 5'h0 && core_factor_x2 != 5'h0)
      else $error("valid decode with a zero factor");
   a_div_legal: assert property (good |-> pci_division inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h8})
      else $error("pci division outside the tables");
   a_comm_legal: assert property (good |-> comm_factor_x2 inside {5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h0c})
      else $error("comm factor outside the tables");
   a_core_legal: assert property (good |-> core_factor_x2 inside {[5'h04:5'h0e], 5'h10})
      else $error("core factor outside the tables");
   a_held_stable: assert property (s_held |-> $stable({config_invalid, comm_factor_x2, core_factor_x2, pci_division}))
      else $error("decode changed without a capture");
   a_resample_cycle: assert property (s_req(32'h0) ##0 hwdata[0] |-> ##[1:3] !decode_valid ##[1:4] decode_valid)
      else $error("resample did not recapture");
   // the select bits land in the register on the edge that ends the data phase and reach the pins one edge later
   a_imp_write: assert property (s_req(32'hc) |=> ##1 {bus_low_impedance_sel_1, bus_low_impedance_sel_0} ==
      ({$past(hwdata[21], 2), $past(hwdata[20], 2)} & {2{SILICON_REV != PCD_REV_FIXED_IMP}}))
      else $error("impedance select does not follow the write");
endmodule // pcd_decoder_asserts
bind pcd_decoder pcd_decoder_asserts #(.SILICON_REV(SILICON_REV)) pcd_decoder_asserts_i (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .decode_valid(decode_valid), .config_invalid(config_invalid), .comm_factor_x2(comm_factor_x2),
   .core_factor_x2(core_factor_x2), .pci_division(pci_division),
   .bus_low_impedance_sel_0(bus_low_impedance_sel_0), .bus_low_impedance_sel_1(bus_low_impedance_sel_1));

// File: verification/tb.sv
// self-checking testbench for the clock mode strap decoder
`timescale 1ns/1ps
module tb
   import pcd_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hready, hresp, dv, inv, imp0, imp1, ms;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [3:0] mh, pdiv;
   logic [2:0] ml;
   logic [4:0] comm, core;
   int errors, compares;
   pcd_decoder pcd_decoder_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .clock_mode_high_field(mh), .clock_mode_low_field(ml), .pci_clock_range_select(ms),
      .decode_valid(dv), .config_invalid(inv), .comm_factor_x2(comm), .core_factor_x2(core),
      .pci_division(pdiv), .bus_low_impedance_sel_0(imp0), .bus_low_impedance_sel_1(imp1));
   pcd_strap_board pcd_strap_board_i (.hclk(hclk), .clock_mode_high_field(mh), .clock_mode_low_field(ml),
      .pci_clock_range_select(ms));
   // ==========================================================
   // shared tasks
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic wait_dv(input logic v);
      int n;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (dv !== v && n < 20);
      cmp({31'h0, dv}, {31'h0, v});
   endtask
   // zero division marks an expected invalid code
   task automatic chk(input logic [7:0] s, input logic [4:0] c, input logic [4:0] k, input logic [3:0] d);
      logic bad;
      bad = (d == 4'h0);
      pcd_strap_board_i.drive(s);
      bus(PCD_CTRL_OFS, 1'b1, 32'h1);
      wait_dv(1'b0);
      wait_dv(1'b1);
      cmp({inv, 3'h0, comm, 3'h0, core, pdiv}, {bad, 3'h0, c, 3'h0, k, d});
      bus(PCD_DECODE_OFS, 1'b0, 32'h0);
      cmp(q, {bad, 11'h0, d, 3'h0, k, 3'h0, c});
      bus(PCD_STRAP_OFS, 1'b0, 32'h0);
      cmp(q, {23'h0, s[7], 1'b0, s[6:0]});
   endtask
   task automatic close_out;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // clock, watchdog and main sequence
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   initial begin
      #400000;
      errors++;
      close_out;
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (2) @(posedge hclk);
      cmp({hready, hresp, dv, inv, comm, core, pdiv, imp0, imp1}, {1'b1, 19'h0});
      hresetn <= 1'b1;
      wait_dv(1'b1);
      cmp({inv, comm, core, pdiv}, {1'b0, 5'h05, 5'h06, 4'h5});
      chk(8'h3c, 5'h06, 5'h09, 4'h3);
      chk(8'h38, 5'h00, 5'h00, 4'h0);
      chk(8'h46, 5'h06, 5'h0d, 4'h4);
      chk(8'h40, 5'h00, 5'h00, 4'h0);
      chk(8'h49, 5'h00, 5'h00, 4'h0);
      chk(8'h4a, 5'h07, 5'h07, 4'h4);
      chk(8'h4d, 5'h07, 5'h0a, 4'h6);
      chk(8'h52, 5'h04, 5'h06, 4'h3);
      chk(8'h33, 5'h05, 5'h08, 4'h3);
      chk(8'h32, 5'h00, 5'h00, 4'h0);
      chk(8'h96, 5'h08, 5'h0c, 4'h6);
      chk(8'h9b, 5'h0a, 5'h10, 4'h5);
      chk(8'ha0, 5'h00, 5'h00, 4'h0);
      chk(8'ha1, 5'h0c, 5'h0c, 4'h6);
      chk(8'ha8, 5'h04, 5'h05, 4'h4);
      chk(8'hb6, 5'h05, 5'h0c, 4'h6);
      chk(8'hb9, 5'h06, 5'h06, 4'h6);
      chk(8'hc6, 5'h06, 5'h0d, 4'h8);
      chk(8'hcc, 5'h07, 5'h09, 4'h8);
      chk(8'hcf, 5'h07, 5'h0c, 4'h6);
      chk(8'hd4, 5'h04, 5'h08, 4'h6);
      chk(8'hd8, 5'h00, 5'h00, 4'h0);
      chk(8'hdd, 5'h05, 5'h09, 4'h8);
      chk(8'he8, 5'h05, 5'h06, 4'h5);
      bus(PCD_SYSCFG_OFS, 1'b1, 32'h0030_0000);
      // the pins follow the select register one edge after the write lands
      repeat (2) @(negedge hclk);
      cmp({30'h0, imp1, imp0}, 32'h3);
      bus(PCD_SYSCFG_OFS, 1'b1, 32'h0010_0000);
      bus(PCD_SYSCFG_OFS, 1'b0, 32'h0);
      cmp(q, 32'h0010_0000);
      cmp({30'h0, imp1, imp0}, 32'h1);
      bus(8'h10, 1'b1, 32'hffff_ffff);
      bus(8'h10, 1'b0, 32'h0);
      cmp(q, 32'h0);
      close_out;
   end
endmodule // tb
